// >>> rtl/oad_pkg.sv
// Package of constants and carrier types for the operand address decoder.
package oad_pkg;

   // ****************************************************************
   // Addressing mode field values
   // ****************************************************************
   localparam logic [1:0] MOD_NO_DISP = 2'h0;
   localparam logic [1:0] MOD_DISP8 = 2'h1;
   localparam logic [1:0] MOD_DISP16 = 2'h2;
   localparam logic [1:0] MOD_REG = 2'h3;
   localparam logic [2:0] RM_DIRECT = 3'h6;

   // ****************************************************************
   // Field positions in the mode byte and the override prefix
   // ****************************************************************
   localparam int MOD_HI = 7;
   localparam int MOD_LO = 6;
   localparam int REG_HI = 5;
   localparam int REG_LO = 3;
   localparam int RM_HI = 2;
   localparam int RM_LO = 0;
   localparam int SEGF_HI = 4;
   localparam int SEGF_LO = 3;
   localparam logic [2:0] SEG_PFX_HEAD = 3'h1;
   localparam logic [2:0] SEG_PFX_TAIL = 3'h6;

   // ****************************************************************
   // Opcodes
   // ****************************************************************
   localparam logic [7:0] OP_CARRY_CLEAR = 8'hf8;
   localparam logic [7:0] OP_CARRY_INVERT = 8'hf5;
   localparam logic [7:0] OP_CARRY_SET = 8'hf9;
   localparam logic [7:0] OP_DIRECTION_CLEAR = 8'hfc;
   localparam logic [7:0] OP_DIRECTION_SET = 8'hfd;
   localparam logic [7:0] OP_IRQ_DISABLE = 8'hfa;
   localparam logic [7:0] OP_IRQ_ENABLE = 8'hfb;
   localparam logic [7:0] OP_HALT = 8'hf4;
   localparam logic [7:0] OP_WAIT = 8'h9b;
   localparam logic [7:0] OP_LOCK = 8'hf0;
   localparam logic [7:0] OP_NOP = 8'h90;

   // ****************************************************************
   // Timing counts in core clocks
   // ****************************************************************
   localparam logic [5:0] CLK_FLAG_OP = 6'h02;
   localparam logic [5:0] CLK_WAIT_OP = 6'h06;
   localparam logic [5:0] CLK_NOP_OP = 6'h03;
   localparam logic [5:0] CLK_EA_CALC = 6'h04;
   localparam logic [5:0] CLK_WORD_EXTRA = 6'h04;

   // ****************************************************************
   // Reset values
   // ****************************************************************
   localparam logic [15:0] RST_WORD = 16'h0000;
   localparam logic [3:0] RST_NIBBLE = 4'h0;

   // ****************************************************************
   // Enumerations and carriers
   // ****************************************************************
   typedef enum logic [1:0] {
      SEG_EXTRA = 2'b00,
      SEG_CODE = 2'b01,
      SEG_STACK = 2'b10,
      SEG_DATA = 2'b11
   } oad_seg_t;

   typedef enum logic [3:0] {
      EREG_NONE = 4'b0000,
      EREG_BASE = 4'b0001,
      EREG_FRAME = 4'b0010,
      EREG_SRC = 4'b0011,
      EREG_DST = 4'b0100
   } oad_ereg_t;

   typedef enum logic [2:0] {
      ST_OP = 3'b000,
      ST_MODRM = 3'b001,
      ST_DISP_LO = 3'b010,
      ST_DISP_HI = 3'b011,
      ST_EA = 3'b100
   } oad_state_t;

   // Register file read values fed in by the execution unit.
   typedef struct packed {
      logic [15:0] base_reg;
      logic [15:0] frame_pointer_reg;
      logic [15:0] src_index_reg;
      logic [15:0] dest_index_reg;
   } oad_regs_t;

   // One decoded instruction as handed downstream.
   typedef struct packed {
      oad_seg_t seg;
      logic [15:0] effective_addr;
      logic [15:0] disp;
      logic mem_operand;
      logic [2:0] reg_sel;
      logic [2:0] rm_reg_sel;
      logic reg_high_byte;
      logic rm_high_byte;
      logic [5:0] clocks;
   } oad_dec_t;

   // Processor-control actions, each a one-cycle pulse.
   typedef struct packed {
      logic carry_clear_op;
      logic carry_invert_op;
      logic carry_set_op;
      logic direction_clear_op;
      logic direction_set_op;
      logic irq_disable_op;
      logic irq_enable_op;
      logic halt_op;
   } oad_ctrl_t;

endpackage

// >>> rtl/oad_ea_adder.sv
// Effective address adder: base plus index plus displacement.
`timescale 1ns/1ps
module oad_ea_adder (
   input wire logic [2:0] i_rm,
   input wire logic i_direct,
   input wire oad_pkg::oad_regs_t i_regs,
   input wire logic [15:0] i_disp,
   output logic [15:0] o_effective_addr,
   output oad_pkg::oad_ereg_t o_addr_reg
);
   import oad_pkg::*;

   logic [15:0] base;
   logic [15:0] index;

   always_comb begin
      base = RST_WORD;
      index = RST_WORD;
      o_addr_reg = EREG_NONE;
      unique case (i_rm)
         3'h0: begin
            base = i_regs.base_reg;
            index = i_regs.src_index_reg;
            o_addr_reg = EREG_BASE;
         end
         3'h1: begin
            base = i_regs.base_reg;
            index = i_regs.dest_index_reg;
            o_addr_reg = EREG_BASE;
         end
         3'h2: begin
            base = i_regs.frame_pointer_reg;
            index = i_regs.src_index_reg;
            o_addr_reg = EREG_FRAME;
         end
         3'h3: begin
            base = i_regs.frame_pointer_reg;
            index = i_regs.dest_index_reg;
            o_addr_reg = EREG_FRAME;
         end
         3'h4: begin
            index = i_regs.src_index_reg;
            o_addr_reg = EREG_SRC;
         end
         3'h5: begin
            index = i_regs.dest_index_reg;
            o_addr_reg = EREG_DST;
         end
         3'h6: begin
            base = i_regs.frame_pointer_reg;
            o_addr_reg = EREG_FRAME;
         end
         3'h7: begin
            base = i_regs.base_reg;
            o_addr_reg = EREG_BASE;
         end
      endcase
      if (i_direct) begin
         base = RST_WORD;
         index = RST_WORD;
         o_addr_reg = EREG_NONE;
      end
   end

   assign o_effective_addr = 16'(base + index + i_disp);

endmodule

// >>> rtl/oad_decoder.sv
// Operand address and processor-control decoder of the CPU core.
// How it works
// - Mode 11 makes the r/m field a register selector.
// - Mode 00 no displacement, 01 sign-extended byte, 10 word low first.
// - Mode 00 with r/m 110 is a direct 16-bit address.
// - Effective address is the r/m base/index pair plus displacement.
// - Displacement bytes follow the mode byte before any immediate data.
// - Effective address calculation takes 4 clocks for every form.
// - Word memory transfers add 4 clocks to the byte time.
// - Override prefix 001ss110; 00 extra, 01 code, 10 stack, 11 data.
// - Register field picks word registers, or low then high bytes.
// - Frame pointer addressed operands default to the stack segment.
// - String destinations via destination index always use extra segment.
// - Carry invert opcode flips carry in 2 clocks.
// - Carry, direction and interrupt flag opcodes take 2 clocks.
// - Halt opcode takes 2 clocks and enters halted state.
// - Wait opcode takes 6 clocks once the test input is low.
// - Lock prefix takes 2 clocks and locks the next instruction.
`timescale 1ns/1ps
module oad_decoder (
   input wire logic i_ref_clk,
   input wire logic i_reset_n,
   input wire logic [7:0] i_byte,
   input wire logic i_byte_valid,
   input wire logic i_has_modrm,
   input wire logic i_word,
   input wire logic i_string_dest,
   input wire logic i_mem_transfer,
   input wire logic [5:0] i_base_clocks,
   input wire oad_pkg::oad_regs_t i_regs,
   input wire logic i_test_n,
   input wire logic i_resume,
   output logic o_byte_ready,
   output oad_pkg::oad_dec_t o_dec,
   output logic o_dec_valid,
   output oad_pkg::oad_ctrl_t o_ctrl,
   output logic [5:0] o_ctrl_clocks,
   output logic o_ctrl_valid,
   output logic o_halted,
   output logic o_waiting,
   output logic o_bus_lock
);
   import oad_pkg::*;

   // ****************************************************************
   // Reset release and pin synchronisers
   // ****************************************************************
   logic rst_meta;
   logic rst_n;
   logic test_meta;
   logic test_n;

   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   always_ff @(posedge i_ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         test_meta <= 1'b1;
         test_n <= 1'b1;
      end else begin
         test_meta <= i_test_n;
         test_n <= test_meta;
      end
   end

   // ****************************************************************
   // Instruction state
   // ****************************************************************
   oad_state_t state;
   oad_state_t next_state;
   logic [7:0] modrm;
   logic [15:0] disp;
   logic [1:0] ea_cnt;
   logic seg_ovr;
   oad_seg_t ovr_seg;
   logic lock_pending;

   logic [1:0] mode;
   logic [2:0] rm;
   logic direct;
   logic is_seg_pfx;
   logic [15:0] ea_sum;
   oad_ereg_t addr_reg;

   assign mode = modrm[MOD_HI:MOD_LO];
   assign rm = modrm[RM_HI:RM_LO];
   assign direct = (mode == MOD_NO_DISP) && (rm == RM_DIRECT);
   assign is_seg_pfx = (i_byte[7:5] == SEG_PFX_HEAD) &&
                       (i_byte[2:0] == SEG_PFX_TAIL);

   // Halt and wait stall the byte stream; the queue must hold its byte.
   assign o_byte_ready = (state == ST_OP || state == ST_MODRM ||
                          state == ST_DISP_LO || state == ST_DISP_HI) &&
                         !o_halted && !o_waiting;

   oad_ea_adder u_ea (
      .i_rm(rm),
      .i_direct(direct),
      .i_regs(i_regs),
      .i_disp(disp),
      .o_effective_addr(ea_sum),
      .o_addr_reg(addr_reg)
   );

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb begin
      next_state = state;
      unique case (state)
         ST_OP: begin
            if (o_byte_ready && i_byte_valid && i_has_modrm) begin
               next_state = ST_MODRM;
            end
         end
         ST_MODRM: begin
            if (i_byte_valid) begin
               if (i_byte[MOD_HI:MOD_LO] == MOD_REG) begin
                  next_state = ST_OP;
               end else if (i_byte[MOD_HI:MOD_LO] != MOD_NO_DISP ||
                            i_byte[RM_HI:RM_LO] == RM_DIRECT) begin
                  next_state = ST_DISP_LO;
               end else begin
                  next_state = ST_EA;
               end
            end
         end
         ST_DISP_LO: begin
            if (i_byte_valid) begin
               next_state = (mode == MOD_DISP8) ? ST_EA : ST_DISP_HI;
            end
         end
         ST_DISP_HI: begin
            if (i_byte_valid) begin
               next_state = ST_EA;
            end
         end
         ST_EA: begin
            if (ea_cnt == 2'(CLK_EA_CALC - 6'h01)) begin
               next_state = ST_OP;
            end
         end
         default: next_state = ST_OP;
      endcase
   end

   always_ff @(posedge i_ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= ST_OP;
      end else begin
         state <= next_state;
      end
   end

   // ****************************************************************
   // Mode byte and displacement capture
   // ****************************************************************
   always_ff @(posedge i_ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         modrm <= 8'h00;
         disp <= RST_WORD;
      end else if (state == ST_MODRM && i_byte_valid) begin
         modrm <= i_byte;
         disp <= RST_WORD;
      end else if (state == ST_DISP_LO && i_byte_valid) begin
         disp <= {{8{i_byte[7]}}, i_byte};
      end else if (state == ST_DISP_HI && i_byte_valid) begin
         disp <= {i_byte, disp[7:0]};
      end
   end

   always_ff @(posedge i_ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ea_cnt <= 2'h0;
      end else if (state == ST_EA) begin
         ea_cnt <= ea_cnt + 2'h1;
      end else begin
         ea_cnt <= 2'h0;
      end
   end

   // ****************************************************************
   // Prefix tracking
   // ****************************************************************
   logic instr_end;
   assign instr_end = (state == ST_OP && o_byte_ready && i_byte_valid &&
                       !i_has_modrm && !is_seg_pfx && i_byte != OP_LOCK) ||
                      (state == ST_MODRM && i_byte_valid &&
                       i_byte[MOD_HI:MOD_LO] == MOD_REG) ||
                      (next_state == ST_OP && state == ST_EA);

   always_ff @(posedge i_ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         seg_ovr <= 1'b0;
         ovr_seg <= SEG_EXTRA;
      end else if (state == ST_OP && o_byte_ready && i_byte_valid &&
                   is_seg_pfx) begin
         seg_ovr <= 1'b1;
         ovr_seg <= oad_seg_t'(i_byte[SEGF_HI:SEGF_LO]);
      end else if (instr_end) begin
         seg_ovr <= 1'b0;
      end
   end

   always_ff @(posedge i_ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         lock_pending <= 1'b0;
         o_bus_lock <= 1'b0;
      end else begin
         if (state == ST_OP && o_byte_ready && i_byte_valid &&
             i_byte == OP_LOCK) begin
            lock_pending <= 1'b1;
         end else if (instr_end) begin
            lock_pending <= 1'b0;
         end
         o_bus_lock <= lock_pending;
      end
   end

   // ****************************************************************
   // Decoded operand output
   // ****************************************************************
   oad_seg_t seg_pick;
   logic [5:0] op_clocks;

   always_comb begin
      seg_pick = SEG_DATA;
      if (addr_reg == EREG_FRAME) begin
         seg_pick = SEG_STACK;
      end
      if (seg_ovr) begin
         seg_pick = ovr_seg;
      end
      if (i_string_dest) begin
         seg_pick = SEG_EXTRA;
      end
      op_clocks = (i_word && i_mem_transfer) ?
                  6'(i_base_clocks + CLK_WORD_EXTRA) : i_base_clocks;
   end

   always_ff @(posedge i_ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_dec <= '0;
         o_dec_valid <= 1'b0;
      end else begin
         o_dec_valid <= 1'b0;
         if (state == ST_MODRM && i_byte_valid &&
             i_byte[MOD_HI:MOD_LO] == MOD_REG) begin
            o_dec <= '0;
            o_dec.seg <= SEG_DATA;
            o_dec.reg_sel <= i_byte[REG_HI:REG_LO];
            o_dec.rm_reg_sel <= i_byte[RM_HI:RM_LO];
            o_dec.reg_high_byte <= !i_word && i_byte[REG_HI];
            o_dec.rm_high_byte <= !i_word && i_byte[RM_HI];
            o_dec.clocks <= i_base_clocks;
            o_dec_valid <= 1'b1;
         end else if (state == ST_EA &&
                      ea_cnt == 2'(CLK_EA_CALC - 6'h01)) begin
            o_dec.seg <= seg_pick;
            o_dec.effective_addr <= ea_sum;
            o_dec.disp <= disp;
            o_dec.mem_operand <= 1'b1;
            o_dec.reg_sel <= modrm[REG_HI:REG_LO];
            o_dec.rm_reg_sel <= rm;
            o_dec.reg_high_byte <= !i_word && modrm[REG_HI];
            o_dec.rm_high_byte <= 1'b0;
            o_dec.clocks <= op_clocks;
            o_dec_valid <= 1'b1;
         end
      end
   end

   // ****************************************************************
   // Processor-control opcodes
   // ****************************************************************
   always_ff @(posedge i_ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_ctrl <= '0;
         o_ctrl_clocks <= 6'h00;
         o_ctrl_valid <= 1'b0;
      end else begin
         o_ctrl <= '0;
         o_ctrl_valid <= 1'b0;
         if (state == ST_OP && o_byte_ready && i_byte_valid) begin
            o_ctrl_clocks <= CLK_FLAG_OP;
            o_ctrl_valid <= 1'b1;
            unique case (i_byte)
               OP_CARRY_CLEAR: o_ctrl.carry_clear_op <= 1'b1;
               OP_CARRY_INVERT: o_ctrl.carry_invert_op <= 1'b1;
               OP_CARRY_SET: o_ctrl.carry_set_op <= 1'b1;
               OP_DIRECTION_CLEAR: o_ctrl.direction_clear_op <= 1'b1;
               OP_DIRECTION_SET: o_ctrl.direction_set_op <= 1'b1;
               OP_IRQ_DISABLE: o_ctrl.irq_disable_op <= 1'b1;
               OP_IRQ_ENABLE: o_ctrl.irq_enable_op <= 1'b1;
               OP_HALT: o_ctrl.halt_op <= 1'b1;
               OP_LOCK: o_ctrl_clocks <= CLK_FLAG_OP;
               OP_NOP: o_ctrl_clocks <= CLK_NOP_OP;
               default: o_ctrl_valid <= 1'b0;
            endcase
         end else if (o_waiting && !test_n) begin
            o_ctrl_clocks <= CLK_WAIT_OP;
            o_ctrl_valid <= 1'b1;
         end
      end
   end

   always_ff @(posedge i_ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_halted <= 1'b0;
      end else if (state == ST_OP && o_byte_ready && i_byte_valid &&
                   i_byte == OP_HALT) begin
         o_halted <= 1'b1;
      end else if (i_resume) begin
         o_halted <= 1'b0;
      end
   end

   always_ff @(posedge i_ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_waiting <= 1'b0;
      end else if (state == ST_OP && o_byte_ready && i_byte_valid &&
                   i_byte == OP_WAIT) begin
         o_waiting <= 1'b1;
      end else if (o_waiting && !test_n) begin
         o_waiting <= 1'b0;
      end
   end

endmodule

// >>> bench/oad_decoder_assertions.sv
// Port-level assertions for the operand address decoder.
`timescale 1ns/1ps
module oad_decoder_assertions (
   input wire logic i_ref_clk,
   input wire logic i_reset_n,
   input wire logic [7:0] i_byte,
   input wire logic i_word,
   input wire logic i_string_dest,
   input wire logic i_mem_transfer,
   input wire logic [5:0] i_base_clocks,
   input wire logic o_byte_ready,
   input wire oad_pkg::oad_dec_t o_dec,
   input wire logic o_dec_valid,
   input wire oad_pkg::oad_ctrl_t o_ctrl,
   input wire logic [5:0] o_ctrl_clocks,
   input wire logic o_ctrl_valid,
   input wire logic o_halted,
   input wire logic o_waiting,
   input wire logic o_bus_lock
);
   import oad_pkg::*;
   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_reset_n);
   AST_DEC_PULSE: assert property (o_dec_valid |=> !o_dec_valid)
      else $error("decode valid held past one cycle");
   AST_CTRL_PULSE: assert property (o_ctrl_valid |=> !o_ctrl_valid)
      else $error("control valid held past one cycle");
   AST_FLAG_CLOCKS: assert property
      (o_ctrl_valid && (|o_ctrl) |-> o_ctrl_clocks == CLK_FLAG_OP)
      else $error("flag opcode clock count wrong");
   AST_HALT_ENTER: assert property
      (o_ctrl_valid && o_ctrl.halt_op |-> ##[0:1] o_halted)
      else $error("halt opcode did not halt");
   AST_HALT_STALL: assert property
      (o_halted && $past(o_halted) |-> !o_byte_ready)
      else $error("bytes accepted while halted");
   AST_WAIT_DONE: assert property ($fell(o_waiting) |-> ##[0:1]
      (o_ctrl_valid && o_ctrl_clocks == CLK_WAIT_OP))
      else $error("wait ended without a six clock report");
   AST_WORD_CLOCKS: assert property
      (o_dec_valid && o_dec.mem_operand |-> o_dec.clocks == i_base_clocks
         + ((i_word && i_mem_transfer) ? CLK_WORD_EXTRA : 6'h00))
      else $error("memory operand clock count wrong");
   AST_STR_SEG: assert property
      (o_dec_valid && o_dec.mem_operand && i_string_dest
         |-> o_dec.seg == SEG_EXTRA)
      else $error("string destination not in extra segment");
   AST_EA_TIME: assert property
      (o_dec_valid && o_dec.mem_operand
         |-> !$past(o_byte_ready) && !$past(o_byte_ready, 4))
      else $error("address calculation shorter than four clocks");
   AST_LOCK_SRC: assert property ($rose(o_bus_lock) |->
      $past(i_byte) == OP_LOCK || $past(i_byte, 2) == OP_LOCK)
      else $error("bus lock raised without a lock prefix");
   cover property (o_dec_valid && o_dec.mem_operand);
   cover property (o_ctrl_valid && o_ctrl.halt_op);
   cover property ($fell(o_waiting));
   cover property ($rose(o_bus_lock));
endmodule

bind oad_decoder oad_decoder_assertions u_chk (.i_ref_clk(i_ref_clk),
   .i_reset_n(i_reset_n), .i_byte(i_byte), .i_word(i_word),
   .i_string_dest(i_string_dest), .i_mem_transfer(i_mem_transfer),
   .i_base_clocks(i_base_clocks), .o_byte_ready(o_byte_ready),
   .o_dec(o_dec), .o_dec_valid(o_dec_valid), .o_ctrl(o_ctrl),
   .o_ctrl_clocks(o_ctrl_clocks), .o_ctrl_valid(o_ctrl_valid),
   .o_halted(o_halted), .o_waiting(o_waiting), .o_bus_lock(o_bus_lock));

// >>> bench/oad_queue_model.sv
// Instruction queue model that offers bytes to the decoder.
`timescale 1ns/1ps
module oad_queue_model (
   input wire logic i_clk,
   input wire logic i_ready,
   output logic [7:0] o_byte,
   output logic o_valid,
   output logic o_has_modrm
);
   logic [8:0] q[$];
   logic [7:0] last;
   task automatic push(input logic [8:0] v);
      q.push_back(v);
   endtask
   initial begin
      o_byte = 8'h00;
      o_valid = 1'b0;
      o_has_modrm = 1'b0;
      last = 8'h00;
   end
   // An idle byte lane shows the inverse of the last byte, never stale data.
   always @(posedge i_clk) begin
      if (o_valid && i_ready) begin
         last = o_byte;
         void'(q.pop_front());
      end
      #1;
      if (q.size() != 0) begin
         o_valid = 1'b1;
         {o_has_modrm, o_byte} = q[0];
      end else begin
         o_valid = 1'b0;
         o_has_modrm = 1'b0;
         o_byte = ~last;
      end
   end
endmodule

// >>> bench/oad_decoder_tb.sv
// Self-checking testbench for the operand address decoder.
`timescale 1ns/1ps
module oad_decoder_tb;
   import oad_pkg::*;
   logic clk, rst_n, modrm, word, sdest, mtr, test_n, resume, bvalid;
   logic ready, dvalid, cvalid, halted, waiting, lock;
   logic [7:0] bval;
   logic [5:0] base_clk, cclk;
   oad_regs_t regs;
   oad_dec_t dec;
   oad_ctrl_t ctrl;
   oad_dec_t dq[$];
   logic [13:0] cq[$];
   logic [7:0] ops [8];
   int err_count, n_checks, seed;
   oad_decoder uut (
      .i_ref_clk(clk), .i_reset_n(rst_n), .i_byte(bval),
      .i_byte_valid(bvalid), .i_has_modrm(modrm), .i_word(word),
      .i_string_dest(sdest), .i_mem_transfer(mtr),
      .i_base_clocks(base_clk), .i_regs(regs), .i_test_n(test_n),
      .i_resume(resume), .o_byte_ready(ready), .o_dec(dec),
      .o_dec_valid(dvalid), .o_ctrl(ctrl), .o_ctrl_clocks(cclk),
      .o_ctrl_valid(cvalid), .o_halted(halted), .o_waiting(waiting),
      .o_bus_lock(lock));
   oad_queue_model u_q (.i_clk(clk), .i_ready(ready), .o_byte(bval),
      .o_valid(bvalid), .o_has_modrm(modrm));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // ****************************************************************
   // Comparison and scoreboard
   // ****************************************************************
   task automatic cmp(input string nm, input logic [15:0] e, g);
      n_checks++;
      if (g !== e) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chk_dec(input oad_dec_t e);
      cmp("mem", 16'(e.mem_operand), 16'(dec.mem_operand));
      cmp("reg", 16'({e.reg_high_byte, e.reg_sel}),
         16'({dec.reg_high_byte, dec.reg_sel}));
      if (e.mem_operand) begin
         cmp("seg", 16'(e.seg), 16'(dec.seg));
         cmp("addr", e.effective_addr, dec.effective_addr);
         cmp("disp", e.disp, dec.disp);
         cmp("clocks", 16'(e.clocks), 16'(dec.clocks));
      end else begin
         cmp("rm", 16'({e.rm_high_byte, e.rm_reg_sel}),
            16'({dec.rm_high_byte, dec.rm_reg_sel}));
      end
   endtask
   task automatic chk_ctrl(input logic [13:0] e);
      cmp("ctrl", 16'(e[13:6]), 16'(ctrl));
      cmp("ctrl_clocks", 16'(e[5:0]), 16'(cclk));
   endtask
   always @(posedge clk) begin
      if (dvalid === 1'b1) begin
         if (dq.size() == 0) cmp("dec_extra", 16'h0, 16'h1);
         else chk_dec(dq.pop_front());
      end
      if (cvalid === 1'b1) begin
         if (cq.size() == 0) cmp("ctrl_extra", 16'h0, 16'h1);
         else chk_ctrl(cq.pop_front());
      end
   end
   task automatic drain();
      int k;
      k = 0;
      while (dq.size() + cq.size() != 0 && k < 60) begin
         @(posedge clk);
         k++;
      end
      if (k == 60) cmp("drain", 16'h0, 16'h1);
      @(posedge clk);
      #1;
   endtask
   function automatic logic [15:0] ea_base(input logic [2:0] rm);
      case (rm)
         3'h0: return regs.base_reg + regs.src_index_reg;
         3'h1: return regs.base_reg + regs.dest_index_reg;
         3'h2: return regs.frame_pointer_reg + regs.src_index_reg;
         3'h3: return regs.frame_pointer_reg + regs.dest_index_reg;
         3'h4: return regs.src_index_reg;
         3'h5: return regs.dest_index_reg;
         3'h6: return regs.frame_pointer_reg;
         default: return regs.base_reg;
      endcase
   endfunction
   // ****************************************************************
   // Stimulus
   // ****************************************************************
   task automatic do_modrm(input logic [1:0] md, input logic [2:0] rm, rg,
                           input logic [2:0] ovr);
      oad_dec_t e;
      logic [15:0] d;
      logic dir;
      regs = {$random(seed), $random(seed)};
      d = 16'($random(seed));
      word = 1'($random(seed));
      sdest = 1'($random(seed));
      mtr = 1'($random(seed));
      base_clk = 6'($random(seed)) & 6'h1f;
      dir = (md == MOD_NO_DISP) && (rm == RM_DIRECT);
      if (md == MOD_DISP8) d = {{8{d[7]}}, d[7:0]};
      if (md == MOD_NO_DISP && !dir) d = 16'h0000;
      e = '0;
      e.mem_operand = (md != MOD_REG);
      e.reg_sel = rg;
      e.reg_high_byte = !word && rg[2];
      e.rm_reg_sel = rm;
      e.rm_high_byte = !word && rm[2];
      e.disp = d;
      e.effective_addr = (dir ? 16'h0000 : ea_base(rm)) + d;
      e.seg = SEG_DATA;
      if (!dir && (rm == 3'h2 || rm == 3'h3 || rm == 3'h6)) e.seg = SEG_STACK;
      if (ovr[2]) e.seg = oad_seg_t'(ovr[1:0]);
      if (sdest) e.seg = SEG_EXTRA;
      e.clocks = base_clk + ((word && mtr) ? CLK_WORD_EXTRA : 6'h00);
      dq.push_back(e);
      if (ovr[2]) u_q.push({1'b0, SEG_PFX_HEAD, ovr[1:0], SEG_PFX_TAIL});
      u_q.push({1'b1, 8'h8b});
      u_q.push({1'b0, md, rg, rm});
      // displacement right after mode byte, low byte first
      if (md == MOD_DISP8 || md == MOD_DISP16 || dir) u_q.push({1'b0, d[7:0]});
      if (md == MOD_DISP16 || dir) u_q.push({1'b0, d[15:8]});
      drain();
   endtask
   task automatic do_ctrl(input logic [7:0] op, input logic [13:0] e);
      cq.push_back(e);
      u_q.push({1'b0, op});
      drain();
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      err_count++;
      test_done();
   end
   initial begin
      seed = 39;
      err_count = 0;
      n_checks = 0;
      {rst_n, word, sdest, mtr, resume, base_clk, regs} = '0;
      test_n = 1'b1;
      ops = '{OP_CARRY_CLEAR, OP_CARRY_INVERT, OP_CARRY_SET,
         OP_DIRECTION_CLEAR, OP_DIRECTION_SET, OP_IRQ_DISABLE,
         OP_IRQ_ENABLE, OP_HALT};
      repeat (10) @(posedge clk);
      cmp("reset_lock", 16'(lock), 16'h0);
      #1 rst_n = 1'b1;
      repeat (4) @(posedge clk);
      #1;
      for (int i = 0; i < 64; i++)
         do_modrm(i[4:3], i[2:0], 3'($random(seed)), {i[5], i[1:0]});
      for (int i = 0; i < 8; i++)
         do_ctrl(ops[i], {8'h80 >> i, CLK_FLAG_OP});
      cmp("halted", 16'(halted), 16'h1);
      cmp("halt_ready", 16'(ready), 16'h0);
      resume = 1'b1;
      @(posedge clk);
      #1 resume = 1'b0;
      repeat (2) @(posedge clk);
      #1 cq.push_back({8'h00, CLK_WAIT_OP});
      u_q.push({1'b0, OP_WAIT});
      repeat (20) @(posedge clk);
      #1 cmp("waiting", 16'(waiting), 16'h1);
      cmp("wait_held", 16'(cq.size()), 16'h1);
      // test input driven low releases the wait
      test_n = 1'b0;
      drain();
      test_n = 1'b1;
      do_ctrl(OP_LOCK, {8'h00, CLK_FLAG_OP});
      cmp("lock_on", 16'(lock), 16'h1);
      do_modrm(MOD_DISP8, 3'h7, 3'h2, 3'h0);
      do_ctrl(OP_CARRY_CLEAR, {8'h80, CLK_FLAG_OP});
      cmp("lock_off", 16'(lock), 16'h0);
      rst_n = 1'b0;
      repeat (2) @(posedge clk);
      #1 rst_n = 1'b1;
      repeat (4) @(posedge clk);
      #1 do_modrm(MOD_NO_DISP, RM_DIRECT, 3'h1, 3'h5);
      test_done();
   end
endmodule
